// *** core/scfg_pkg.sv ***
package scfg_pkg;

  // register offsets on the device (15-bit instruction address)
  localparam logic [14:0] OFS_IF_CFG    = 15'h0000;
  localparam logic [14:0] OFS_CHIP_TYPE = 15'h0003;
  localparam logic [14:0] OFS_PID_LO    = 15'h0004;
  localparam logic [14:0] OFS_PID_HI    = 15'h0005;
  localparam logic [14:0] OFS_SI_REV    = 15'h0006;
  localparam logic [14:0] OFS_TUNE_UPD  = 15'h0113;
  localparam logic [14:0] OFS_TW_LO     = 15'h0114;
  localparam logic [14:0] OFS_TW_HI     = 15'h0115;

  // interface_config fields, each function mirrored in two bits
  localparam int CFG_RST_HI = 7;
  localparam int CFG_LSB_HI = 6;
  localparam int CFG_INC_HI = 5;
  localparam int CFG_SDO_HI = 4;
  localparam int CFG_SDO_LO = 3;
  localparam int CFG_INC_LO = 2;
  localparam int CFG_LSB_LO = 1;
  localparam int CFG_RST_LO = 0;
  localparam int TUNE_UPD_BIT = 0;
  localparam logic [7:0]  CFG_RESET = 8'h00;
  localparam logic [15:0] TW_RESET  = 16'h0000;

  // instruction word layout and frame counts
  localparam int          RW_BIT     = 15;
  localparam logic [3:0]  INSTR_LAST = 4'hf;
  localparam logic [2:0]  BYTE_LAST  = 3'h7;

  // timing: serial clock no faster than 10 MHz, half period rounded up
  localparam int CLK_HZ      = 200_000_000;
  localparam int SCLK_MAX_HZ = 10_000_000;
  localparam int SCLK_HALF   = (CLK_HZ + 2 * SCLK_MAX_HZ - 1)
                               / (2 * SCLK_MAX_HZ);

  // host command registers
  localparam logic [3:0] HOST_CTRL = 4'h0;
  localparam logic [3:0] HOST_DATA = 4'h1;
  localparam logic [3:0] HOST_GO   = 4'h2;
  localparam int CTRL_RW  = 15;
  localparam int CTRL_LSB = 16;
  localparam int CTRL_4W  = 17;
  localparam int CTRL_NB  = 18;

  typedef enum logic {
    PH_INSTR = 1'b0,
    PH_DATA  = 1'b1
  } phase_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_LEAD = 3'b001,
    ST_LOW  = 3'b010,
    ST_HIGH = 3'b011,
    ST_TAIL = 3'b100,
    ST_GAP  = 3'b101
  } host_st_t;

endpackage

// *** core/spi_link_if.sv ***
`timescale 1ns/100ps
interface spi_link_if;
  logic sclk;
  logic cs_n;
  logic host_sdio_o;
  logic host_sdio_oe;
  logic dev_sdio_o;
  logic dev_sdio_oe;
  logic sdo_o;
  logic sdo_oe;
  logic sdio;
  logic serial_out_pin;

  // wire levels resolved from the enables, pulled high when free
  assign sdio = dev_sdio_oe ? dev_sdio_o :
                (host_sdio_oe ? host_sdio_o : 1'b1);
  assign serial_out_pin = sdo_oe ? sdo_o : 1'b1;

  modport host (
    output sclk,
    output cs_n,
    output host_sdio_o,
    output host_sdio_oe,
    input  sdio,
    input  serial_out_pin
  );

  modport dev (
    input  sclk,
    input  cs_n,
    input  sdio,
    output dev_sdio_o,
    output dev_sdio_oe,
    output sdo_o,
    output sdo_oe
  );
endinterface

// *** core/serial_config_port.sv ***
// Notes on behaviour
// - first 16 rising edges are instruction
// - chip select high restarts instruction phase
// - each data byte takes eight clocks
// - writes land at byte end; tuning waits
// - instruction bit 15 one means read
// - bits 14..0 give the start address
// - step bits pick increment or decrement
// - later bytes use the stepped address
// - inputs sampled on serial clock rise
// - read data changes on serial clock fall
// - host keeps serial clock at 10 MHz
// - data pin released while chip select high
// - host holds select low whole cycle
// - order bits choose MSB or LSB first
// - LSB first: address, direction, data bit0 up
// - output-select bits move reads to out pin
// - three-wire mode after reset
// - chip type code at 0x003
// - product identifier at 0x005 and 0x004
// - silicon revision in 0x006 bits 4..0
// - 0xBD soft reset, 0x3C four-wire increment
//
// Design decision made here: the plain strobed port.
`timescale 1ns/100ps
module serial_config_port
  import scfg_pkg::*;
#(
  parameter logic [7:0]  CHIP_TYPE_CODE = 8'h5a,   // arbitrary value
  parameter logic [15:0] PRODUCT_CODE   = 16'h1234, // arbitrary value
  parameter logic [4:0]  REVISION_CODE  = 5'h03    // arbitrary value
) (
  input  wire logic        clk,
  input  wire logic        nrst,
  spi_link_if.dev          link,
  output logic [15:0]      frequency_tuning_word,
  output logic [7:0]       interface_config
);

  logic [2:0]  sclk_s_r;
  logic [2:0]  cs_s_r;
  logic [2:0]  din_s_r;
  logic        sclk_q_r;
  logic        cs_q_r;
  logic        sclk_rise;
  logic        sclk_fall;
  logic        active;
  logic        din;
  phase_t      phase_r;
  logic [3:0]  bit_cnt_r;
  logic [15:0] instr_r;
  logic [15:0] instr_nxt;
  logic [14:0] addr_r;
  logic [14:0] addr_step;
  logic        rd_r;
  logic [7:0]  rx_r;
  logic [7:0]  rx_nxt;
  logic [7:0]  tx_r;
  logic        instr_done;
  logic        byte_done;
  logic        wr_en;
  logic        soft_rst;
  logic        rd_drive;
  logic [7:0]  cfg_r;
  logic [15:0] tune_stage_r;
  logic [15:0] tune_r;
  logic        lsb_first;
  logic        addr_inc;
  logic        four_wire;
  logic        sdio_o_r;
  logic        sdio_oe_r;
  logic        sdo_o_r;
  logic        sdo_oe_r;

  // address step by one either way
  function automatic logic [14:0] step_addr(input logic [14:0] a,
                                            input logic        inc);
    step_addr = inc ? a + 15'h0001 : a - 15'h0001;
  endfunction

  // shift one serial bit into a byte in the chosen order
  function automatic logic [7:0] shift_byte(input logic [7:0] v,
                                            input logic       b,
                                            input logic       lsb);
    shift_byte = lsb ? {b, v[7:1]} : {v[6:0], b};
  endfunction

  // register read map
  function automatic logic [7:0] rd_val(input logic [14:0] a);
    case (a)
      OFS_IF_CFG:    rd_val = cfg_r;
      OFS_CHIP_TYPE: rd_val = CHIP_TYPE_CODE;
      OFS_PID_LO:    rd_val = PRODUCT_CODE[7:0];
      OFS_PID_HI:    rd_val = PRODUCT_CODE[15:8];
      OFS_SI_REV:    rd_val = {3'h0, REVISION_CODE};
      OFS_TW_LO:     rd_val = tune_stage_r[7:0];
      OFS_TW_HI:     rd_val = tune_stage_r[15:8];
      default:       rd_val = 8'h00;
    endcase
  endfunction

  // mirrored configuration bits, either copy enables the mode
  assign lsb_first = cfg_r[CFG_LSB_HI] | cfg_r[CFG_LSB_LO];
  assign addr_inc  = cfg_r[CFG_INC_HI] | cfg_r[CFG_INC_LO];
  assign four_wire = cfg_r[CFG_SDO_HI] | cfg_r[CFG_SDO_LO];

  // three-stage input synchronisers
  always_ff @(posedge clk) begin
    if (!nrst) begin
      sclk_s_r <= 3'h0;
      cs_s_r   <= 3'h7;
      din_s_r  <= 3'h7;
    end else begin
      sclk_s_r <= {sclk_s_r[1:0], link.sclk};
      cs_s_r   <= {cs_s_r[1:0], link.cs_n};
      din_s_r  <= {din_s_r[1:0], link.sdio};
    end
  end

  // filtered levels, changed once stages two and three agree
  always_ff @(posedge clk) begin
    if (!nrst) begin
      sclk_q_r <= 1'b0;
      cs_q_r   <= 1'b1;
    end else begin
      if (sclk_s_r[2] == sclk_s_r[1]) begin
        sclk_q_r <= sclk_s_r[2];
      end
      if (cs_s_r[2] == cs_s_r[1]) begin
        cs_q_r <= cs_s_r[2];
      end
    end
  end

  // serial clock edges and frame decode
  assign sclk_rise = sclk_s_r[2] & sclk_s_r[1] & ~sclk_q_r;
  assign sclk_fall = ~sclk_s_r[2] & ~sclk_s_r[1] & sclk_q_r;
  assign active    = ~cs_q_r;
  assign din       = din_s_r[2];
  assign instr_nxt = lsb_first ? {din, instr_r[15:1]}
                               : {instr_r[14:0], din};
  assign rx_nxt    = shift_byte(rx_r, din, lsb_first);
  assign instr_done = sclk_rise & active & (phase_r == PH_INSTR)
                      & (bit_cnt_r == INSTR_LAST);
  assign byte_done = sclk_rise & active & (phase_r == PH_DATA)
                     & (bit_cnt_r[2:0] == BYTE_LAST);
  assign wr_en     = byte_done & ~rd_r;
  assign addr_step = step_addr(addr_r, addr_inc);
  assign soft_rst  = wr_en & (addr_r == OFS_IF_CFG)
                     & (rx_nxt[CFG_RST_HI] | rx_nxt[CFG_RST_LO]);
  assign rd_drive  = active & (phase_r == PH_DATA) & rd_r;

  // phase and bit counter, restarted by chip select
  always_ff @(posedge clk) begin
    if (!nrst || !active) begin
      phase_r   <= PH_INSTR;
      bit_cnt_r <= 4'h0;
    end else if (sclk_rise) begin
      if (instr_done) begin
        phase_r <= PH_DATA;
      end
      if (instr_done || byte_done) begin
        bit_cnt_r <= 4'h0;
      end else begin
        bit_cnt_r <= bit_cnt_r + 4'h1;
      end
    end
  end

  // instruction and receive shift registers
  always_ff @(posedge clk) begin
    if (!nrst) begin
      instr_r <= 16'h0000;
      rx_r    <= 8'h00;
    end else if (sclk_rise && active) begin
      if (phase_r == PH_INSTR) begin
        instr_r <= instr_nxt;
      end else begin
        rx_r <= rx_nxt;
      end
    end
  end

  // direction and running address
  always_ff @(posedge clk) begin
    if (!nrst) begin
      addr_r <= 15'h0000;
      rd_r   <= 1'b0;
    end else if (instr_done) begin
      addr_r <= instr_nxt[14:0];
      rd_r   <= instr_nxt[RW_BIT];
    end else if (byte_done) begin
      addr_r <= addr_step;
    end
  end

  // read byte loaded at byte start, shifted out on falls
  always_ff @(posedge clk) begin
    if (!nrst) begin
      tx_r <= 8'h00;
    end else if (instr_done) begin
      tx_r <= rd_val(instr_nxt[14:0]);
    end else if (byte_done) begin
      tx_r <= rd_val(addr_step);
    end else if (sclk_fall && rd_drive) begin
      tx_r <= lsb_first ? {1'b0, tx_r[7:1]} : {tx_r[6:0], 1'b0};
    end
  end

  // output pins, released outside a read data phase
  always_ff @(posedge clk) begin
    if (!nrst || !active) begin
      sdio_o_r  <= 1'b0;
      sdio_oe_r <= 1'b0;
      sdo_o_r   <= 1'b0;
      sdo_oe_r  <= 1'b0;
    end else if (sclk_fall && rd_drive) begin
      sdio_o_r  <= lsb_first ? tx_r[0] : tx_r[7];
      sdo_o_r   <= lsb_first ? tx_r[0] : tx_r[7];
      sdio_oe_r <= ~four_wire;
      sdo_oe_r  <= four_wire;
    end else if (!rd_drive) begin
      sdio_oe_r <= 1'b0;
      sdo_oe_r  <= 1'b0;
    end
  end

  // interface configuration, immediate on the last bit
  always_ff @(posedge clk) begin
    if (!nrst) begin
      cfg_r <= CFG_RESET;
    end else if (wr_en && addr_r == OFS_IF_CFG) begin
      cfg_r <= rx_nxt;
    end
  end

  // staged tuning word bytes
  always_ff @(posedge clk) begin
    if (!nrst || soft_rst) begin
      tune_stage_r <= TW_RESET;
    end else if (wr_en && addr_r == OFS_TW_LO) begin
      tune_stage_r[7:0] <= rx_nxt;
    end else if (wr_en && addr_r == OFS_TW_HI) begin
      tune_stage_r[15:8] <= rx_nxt;
    end
  end

  // active tuning word, loaded by the update request, cleared by soft reset
  always_ff @(posedge clk) begin
    if (!nrst || soft_rst) begin
      tune_r <= TW_RESET;
    end else if (wr_en && addr_r == OFS_TUNE_UPD
                 && rx_nxt[TUNE_UPD_BIT]) begin
      tune_r <= tune_stage_r;
    end
  end

  assign link.dev_sdio_o       = sdio_o_r;
  assign link.dev_sdio_oe      = sdio_oe_r;
  assign link.sdo_o            = sdo_o_r;
  assign link.sdo_oe           = sdo_oe_r;
  assign frequency_tuning_word = tune_r;
  assign interface_config      = cfg_r;

endmodule // serial_config_port

// *** core/serial_config_host.sv ***
`timescale 1ns/100ps
module serial_config_host
  import scfg_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic [3:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic [31:0]      rdata,
  spi_link_if.host         link
);

  localparam logic [4:0] HALF_LAST = 5'(SCLK_HALF - 1);

  host_st_t    st_r;
  logic [19:0] ctrl_r;
  logic [31:0] data_r;
  logic [31:0] rdata_r;
  logic [4:0]  half_r;
  logic [5:0]  idx_r;
  logic [5:0]  idx_last;
  logic        half_done;
  logic        sclk_r;
  logic        cs_n_r;
  logic        sdio_o_r;
  logic        sdio_oe_r;
  logic [2:0]  sdio_s_r;
  logic [2:0]  sdo_s_r;
  logic        sdio_q_r;
  logic        sdo_q_r;
  logic        lsb;
  logic        is_rd;

  // position of serial bit k in instruction or data vector
  function automatic logic [4:0] bit_pos(input logic [5:0] k,
                                         input logic       lsb_m);
    logic [5:0] d;
    d = k - 6'd16;
    if (k < 6'd16) begin
      bit_pos = lsb_m ? k[4:0] : 5'(6'd15 - k);
    end else begin
      bit_pos = {d[4:3], lsb_m ? d[2:0] : 3'(3'h7 - d[2:0])};
    end
  endfunction

  // serial bit k to send
  function automatic logic tx_bit(input logic [5:0] k);
    if (k < 6'd16) begin
      tx_bit = ctrl_r[bit_pos(k, lsb)];
    end else begin
      tx_bit = data_r[bit_pos(k, lsb)];
    end
  endfunction

  assign lsb       = ctrl_r[CTRL_LSB];
  assign is_rd     = ctrl_r[CTRL_RW];
  assign idx_last  = 6'd23 + {1'b0, ctrl_r[CTRL_NB+1:CTRL_NB], 3'h0};
  assign half_done = (half_r == HALF_LAST);

  // return-data synchronisers
  always_ff @(posedge clk) begin
    if (!nrst) begin
      sdio_s_r <= 3'h7;
      sdo_s_r  <= 3'h7;
      sdio_q_r <= 1'b1;
      sdo_q_r  <= 1'b1;
    end else begin
      sdio_s_r <= {sdio_s_r[1:0], link.sdio};
      sdo_s_r  <= {sdo_s_r[1:0], link.serial_out_pin};
      if (sdio_s_r[2] == sdio_s_r[1]) begin
        sdio_q_r <= sdio_s_r[2];
      end
      if (sdo_s_r[2] == sdo_s_r[1]) begin
        sdo_q_r <= sdo_s_r[2];
      end
    end
  end

  // half-period timer of the generated serial clock
  always_ff @(posedge clk) begin
    if (!nrst || st_r == ST_IDLE || half_done) begin
      half_r <= 5'h00;
    end else begin
      half_r <= half_r + 5'h01;
    end
  end

  // frame sequencer
  always_ff @(posedge clk) begin
    if (!nrst) begin
      st_r      <= ST_IDLE;
      idx_r     <= 6'h00;
      sclk_r    <= 1'b0;
      cs_n_r    <= 1'b1;
      sdio_o_r  <= 1'b0;
      sdio_oe_r <= 1'b0;
    end else begin
      case (st_r)
        ST_IDLE: begin
          if (wr && addr == HOST_GO) begin
            st_r   <= ST_LEAD;
            cs_n_r <= 1'b0;
            idx_r  <= 6'h00;
          end
        end
        ST_LEAD: begin
          if (half_done) begin
            st_r      <= ST_LOW;
            sdio_o_r  <= tx_bit(6'h00);
            sdio_oe_r <= 1'b1;
          end
        end
        ST_LOW: begin
          if (half_done) begin
            st_r   <= ST_HIGH;
            sclk_r <= 1'b1;
          end
        end
        ST_HIGH: begin
          if (half_done) begin
            sclk_r <= 1'b0;
            if (idx_r == idx_last) begin
              st_r      <= ST_TAIL;
              sdio_oe_r <= 1'b0;
            end else begin
              st_r      <= ST_LOW;
              idx_r     <= idx_r + 6'h01;
              sdio_o_r  <= tx_bit(idx_r + 6'h01);
              sdio_oe_r <= (idx_r < 6'd15) | ~is_rd;
            end
          end
        end
        ST_TAIL: begin
          if (half_done) begin
            st_r   <= ST_GAP;
            cs_n_r <= 1'b1;
          end
        end
        ST_GAP: begin
          if (half_done) begin
            st_r <= ST_IDLE;
          end
        end
        default: begin
          st_r <= ST_IDLE;
        end
      endcase
    end
  end

  // command registers; read data captured late in each high phase
  always_ff @(posedge clk) begin
    if (!nrst) begin
      ctrl_r <= 20'h0_0000;
      data_r <= 32'h0000_0000;
    end else if (st_r == ST_IDLE && wr) begin
      if (addr == HOST_CTRL) begin
        ctrl_r <= wdata[19:0];
      end else if (addr == HOST_DATA) begin
        data_r <= wdata;
      end
    end else if (st_r == ST_HIGH && half_done && is_rd
                 && idx_r > 6'd15) begin
      data_r[bit_pos(idx_r, lsb)] <=
        ctrl_r[CTRL_4W] ? sdo_q_r : sdio_q_r;
    end
  end

  // register read port, data in the following cycle
  always_ff @(posedge clk) begin
    if (!nrst) begin
      rdata_r <= 32'h0000_0000;
    end else if (rd) begin
      case (addr)
        HOST_CTRL: rdata_r <= {12'h000, ctrl_r};
        HOST_DATA: rdata_r <= data_r;
        HOST_GO:   rdata_r <= {31'h0000_0000, st_r != ST_IDLE};
        default:   rdata_r <= 32'h0000_0000;
      endcase
    end
  end

  assign rdata             = rdata_r;
  assign link.sclk         = sclk_r;
  assign link.cs_n         = cs_n_r;
  assign link.host_sdio_o  = sdio_o_r;
  assign link.host_sdio_oe = sdio_oe_r;

endmodule // serial_config_host

// *** sim/scfg_props.sv ***
`timescale 1ns/100ps
module scfg_props (
  input wire logic clk,
  input wire logic nrst,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic host_sdio_o,
  input wire logic host_sdio_oe,
  input wire logic dev_sdio_o,
  input wire logic dev_sdio_oe,
  input wire logic sdo_o,
  input wire logic sdo_oe,
  input wire logic serial_out_pin
);
  logic       sclk_q;
  logic [5:0] rise_cnt;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  // serial clock rises counted from chip select low
  always_ff @(posedge clk) begin
    if (!nrst || cs_n) begin
      rise_cnt <= 6'h00;
    end else if (sclk && !sclk_q) begin
      rise_cnt <= rise_cnt + 6'h01;
    end
  end

  // previous serial clock level for edge finding
  always_ff @(posedge clk) begin
    sclk_q <= nrst ? sclk : 1'h0;
  end

  release_cs_a: assert property (
    cs_n [*6] |-> !dev_sdio_oe && !sdo_oe && serial_out_pin)
    else $error("device pin driven while deselected");
  instr_quiet_a: assert property (
    !cs_n && rise_cnt < 6'h10 |-> !dev_sdio_oe && !sdo_oe)
    else $error("device drives during instruction");
  instr_drive_a: assert property (
    !cs_n && sclk && rise_cnt < 6'h10 |-> host_sdio_oe)
    else $error("instruction bit not driven by host");
  no_contend_a: assert property (
    !(dev_sdio_oe && host_sdio_oe))
    else $error("both ends drive the shared pin");
  one_outpin_a: assert property (
    !(dev_sdio_oe && sdo_oe))
    else $error("read data on both pins");
  start_fall_a: assert property (
    $rose(dev_sdio_oe) || $rose(sdo_oe) |-> !cs_n && !sclk)
    else $error("read drive starts off the falling edge");
  sdio_fall_a: assert property (
    $changed(dev_sdio_o) && $past(dev_sdio_oe) && dev_sdio_oe
      |-> !sclk && !$past(sclk))
    else $error("shared pin read bit moved near a rise");
  sdo_fall_a: assert property (
    $changed(sdo_o) && $past(sdo_oe) && sdo_oe |-> !sclk && !$past(sclk))
    else $error("output pin read bit moved near a rise");
  frame_len_a: assert property (
    $rose(cs_n) |-> rise_cnt >= 6'h18 && rise_cnt[2:0] == 3'h0)
    else $error("frame not instruction plus whole bytes");
  sclk_high_a: assert property (
    $rose(sclk) |-> sclk [*8] ##1 sclk ##1 sclk ##1 !sclk)
    else $error("serial clock high time wrong");
  sclk_low_a: assert property (
    $fell(sclk) |-> (!sclk) [*8] ##1 !sclk)
    else $error("serial clock low time too short");
  sclk_idle_a: assert property (
    $rose(sclk) |-> !cs_n && !$past(cs_n))
    else $error("serial clock toggles while deselected");
  host_hold_a: assert property (
    sclk && $past(sclk) |-> $stable(host_sdio_o) && $stable(host_sdio_oe))
    else $error("host data moved while clock high");

  cover property ($rose(dev_sdio_oe));
  cover property ($rose(sdo_oe));
  cover property ($rose(cs_n) && rise_cnt == 6'h30);
  cover property ($rose(cs_n) && rise_cnt == 6'h28);
endmodule // scfg_props

// *** sim/tb_top.sv ***
`timescale 1ns/100ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin fail_count++; \
  $display("unexpected at %0t got %h exp %h", $time, (g), (e)); end end
module tb_top;
  import scfg_pkg::*;
  // identity values are arbitrary
  localparam logic [7:0]  CT  = 8'h2c;
  localparam logic [15:0] PID = 16'h6e31;
  localparam logic [4:0]  REV = 5'h11;

  logic        clk;
  logic        nrst;
  logic [3:0]  addr;
  logic [31:0] wdata;
  logic        wr;
  logic        rd;
  logic [31:0] rdata;
  logic [15:0] tw;
  logic [7:0]  icfg;
  logic [31:0] seed;
  logic [31:0] res;
  logic [31:0] rnd;
  logic [15:0] tw_exp;
  logic        cur_lsb;
  logic        cur_4w;
  logic        ml;
  logic        mw;
  int          fail_count;
  int          n_tests;

  spi_link_if lnk ();

  serial_config_host i_serial_config_host (
    .clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .link(lnk.host));

  serial_config_port #(.CHIP_TYPE_CODE(CT), .PRODUCT_CODE(PID),
    .REVISION_CODE(REV)) i_serial_config_port (
    .clk(clk), .nrst(nrst), .link(lnk.dev),
    .frequency_tuning_word(tw), .interface_config(icfg));

  scfg_props i_scfg_props (
    .clk(clk), .nrst(nrst), .sclk(lnk.sclk), .cs_n(lnk.cs_n),
    .host_sdio_o(lnk.host_sdio_o), .host_sdio_oe(lnk.host_sdio_oe),
    .dev_sdio_o(lnk.dev_sdio_o), .dev_sdio_oe(lnk.dev_sdio_oe),
    .sdo_o(lnk.sdo_o), .sdo_oe(lnk.sdo_oe),
    .serial_out_pin(lnk.serial_out_pin));

  // 200 MHz clock
  always #2.5 clk = ~clk;

  // xorshift source, fixed start
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // expected chip information byte
  function automatic logic [7:0] id_byte(input logic [14:0] a);
    case (a)
      OFS_CHIP_TYPE: return CT;
      OFS_PID_LO:    return PID[7:0];
      OFS_PID_HI:    return PID[15:8];
      OFS_SI_REV:    return {3'h0, REV};
      default:       return 8'h00;
    endcase
  endfunction

  // config byte: increment, optional lsb first and four-wire
  function automatic logic [7:0] cfg_of(input logic lsb, input logic w4);
    return 8'h24 | (lsb ? 8'h42 : 8'h00) | (w4 ? 8'h18 : 8'h00);
  endfunction

  task automatic end_sim();
    $display("tests %0d failures %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'h1;
    @(posedge clk);
    wr    <= 1'h0;
  endtask

  task automatic reg_rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd   <= 1'h1;
    @(posedge clk);
    rd   <= 1'h0;
    @(posedge clk);
    d = rdata;
  endtask

  // one framed transfer through the host, bounded busy poll
  task automatic xfer(input logic [14:0] a, input logic rnw, input int nb,
                      input logic [31:0] d, output logic [31:0] r);
    logic [31:0] st;
    st = 32'h0000_0001;
    reg_wr(HOST_CTRL, {12'h000, 2'(nb - 1), cur_4w, cur_lsb, rnw, a});
    reg_wr(HOST_DATA, d);
    reg_wr(HOST_GO, 32'h0000_0001);
    for (int i = 0; i < 1000 && st[0] !== 1'h0; i++) begin
      reg_rd(HOST_GO, st);
    end
    if (st[0] !== 1'h0) begin
      fail_count++;
      end_sim();
    end
    reg_rd(HOST_DATA, r);
  endtask

  initial begin
    clk = 1'h0;
    nrst = 1'h0;
    addr = 4'h0;
    wdata = 32'h0000_0000;
    wr = 1'h0;
    rd = 1'h0;
    seed = 32'h0000_003c;
    cur_lsb = 1'h0;
    cur_4w = 1'h0;
    fail_count = 0;
    n_tests = 0;
    repeat (10) @(posedge clk);
    nrst <= 1'h1;
    @(posedge clk);
    `CHK(icfg, CFG_RESET)
    `CHK(tw, TW_RESET)
    // three-wire decrementing read of the chip information
    xfer(OFS_SI_REV, 1'h1, 4, 32'h0000_0000, res);
    `CHK(res, {CT, PID[7:0], PID[15:8], {3'h0, REV}})
    // decrementing write of staged word, held until update
    xfer(OFS_TW_HI, 1'h0, 2, 32'h0000_a53c, res);
    `CHK(tw, TW_RESET)
    xfer(OFS_TUNE_UPD, 1'h0, 1, 32'h0000_0001, res);
    tw_exp = 16'h3ca5;
    `CHK(tw, tw_exp)
    // every order and pin mode, random tuning words
    for (int m = 0; m < 4; m++) begin
      ml = (m >= 2);
      mw = (m == 1 || m == 2);
      xfer(OFS_IF_CFG, 1'h0, 1, {24'h00_0000, cfg_of(ml, mw)}, res);
      cur_lsb = ml;
      cur_4w = mw;
      `CHK(icfg, cfg_of(ml, mw))
      rnd = xs();
      xfer(OFS_TW_LO, 1'h0, 2, {16'h0000, rnd[15:0]}, res);
      `CHK(tw, tw_exp)
      xfer(OFS_TUNE_UPD, 1'h0, 1, 32'h0000_0001, res);
      tw_exp = rnd[15:0];
      `CHK(tw, tw_exp)
      xfer(OFS_TUNE_UPD, 1'h1, 3, 32'h0000_0000, res);
      `CHK(res, {8'h00, rnd[15:0], 8'h00})
      xfer(OFS_CHIP_TYPE, 1'h1, 4, 32'h0000_0000, res);
      `CHK(res, {id_byte(OFS_SI_REV), PID, CT})
      xfer(15'h7ff0, 1'h1, 1, 32'h0000_0000, res);
      `CHK(res, 32'h0000_0000)
    end
    // soft reset then the documented four-wire setting
    xfer(OFS_IF_CFG, 1'h0, 1, 32'h0000_00bd, res);
    cur_lsb = 1'h0;
    cur_4w = 1'h1;
    `CHK(icfg, 8'hbd)
    `CHK(tw, TW_RESET)
    xfer(OFS_IF_CFG, 1'h0, 1, 32'h0000_003c, res);
    `CHK(icfg, 8'h3c)
    xfer(OFS_CHIP_TYPE, 1'h1, 1, 32'h0000_0000, res);
    `CHK(res[7:0], CT)
    // unmapped host register
    reg_wr(4'h7, 32'hffff_ffff);
    reg_rd(4'hf, res);
    `CHK(res, 32'h0000_0000)
    end_sim();
  end
endmodule // tb_top
